// *** pkg/cbt_pkg.sv ***
// Purpose: Shared constants and types for the CAN bit timing block
// Assumes: 8-bit register port, one 50 MHz clock
// Notes: Register offsets are indices on the plain register port
package cbt_pkg;
  localparam int ADDR_W = 2;
  localparam logic [1:0] PJ_ADDR = 2'h0;
  localparam logic [1:0] SS_ADDR = 2'h1;
  localparam logic [1:0] STAT_ADDR = 2'h2;
  localparam int JUMP_MSB = 7;
  localparam int JUMP_LSB = 6;
  localparam int PRESC_MSB = 5;
  localparam int PRESC_LSB = 0;
  localparam int TRIPLE_BIT = 7;
  localparam int SEG2_MSB = 6;
  localparam int SEG2_LSB = 4;
  localparam int SEG1_MSB = 3;
  localparam int SEG1_LSB = 0;
  localparam int STAT_INIT_BIT = 0;
  localparam int STAT_RXBIT_BIT = 1;
  localparam int STAT_CLKSEL_BIT = 2;
  localparam int STAT_SEG1_BIT = 3;
  localparam int STAT_SEG2_BIT = 4;
  localparam logic [7:0] PJ_RESET = 8'h00;
  localparam logic [7:0] SS_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    CBT_SYNC = 2'b00,
    CBT_SEG1 = 2'b01,
    CBT_SEG2 = 2'b10
  } cbt_seg_t;
endpackage

// *** pkg/cbt_quantum_if.sv ***
// Purpose: Link between the bit timing core and its quantum generator
// Assumes: Single clock domain
// Notes: Tick is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
interface cbt_quantum_if;
  logic run;
  logic clock_select;
  logic osc_clock_en;
  logic [5:0] quantum_prescaler;
  logic quantum_tick;

  modport core (
    output run,
    output clock_select,
    output osc_clock_en,
    output quantum_prescaler,
    input quantum_tick
  );
  modport gen (
    input run,
    input clock_select,
    input osc_clock_en,
    input quantum_prescaler,
    output quantum_tick
  );
endinterface
`default_nettype wire

// *** src/cbt_quantum_gen.sv ***
// Purpose: Time quantum tick from the selected CAN clock enable
// Assumes: Bus clock is clk_i itself, oscillator arrives as an enable
// Notes: Counter is held at zero while the core is stopped
`timescale 1ns/1ps
`default_nettype none
module cbt_quantum_gen (
  input wire logic clk_i,     // System clock
  input wire logic reset_i,   // Synchronous reset, high
  cbt_quantum_if.gen q        // Control and tick
);
  import cbt_pkg::*;

  typedef struct packed {
    logic [5:0] count;
    logic tick;
  } cbt_gen_state_t;

  localparam cbt_gen_state_t GEN_RESET = '{count: 6'h00, tick: 1'b0};

  cbt_gen_state_t st;
  cbt_gen_state_t next_st;
  logic can_clock_en;

  always_comb begin
    can_clock_en = q.clock_select ? 1'b1 : q.osc_clock_en;
    next_st = st;
    next_st.tick = 1'b0;
    if (!q.run) begin
      next_st.count = 6'h00;
    end else if (can_clock_en) begin
      if (st.count >= q.quantum_prescaler) begin
        next_st.count = 6'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.count = st.count + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= GEN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign q.quantum_tick = st.tick;
endmodule
`default_nettype wire

// *** src/cbt_top.sv ***
// Purpose: CAN bit timing registers and bit timing core
// Assumes: Init handshake and frame engine live elsewhere on clk_i
// Notes: Receive pin is synchronised before any use
`timescale 1ns/1ps
`default_nettype none
module cbt_top (
  input wire logic clk_i,                                 // System clock, 50 MHz
  input wire logic reset_i,                               // Synchronous reset, high
  input wire logic [cbt_pkg::ADDR_W-1:0] addr_i,          // Register index
  input wire logic [7:0] wdata_i,                         // Write data
  input wire logic write_i,                               // Write strobe
  input wire logic read_i,                                // Read strobe
  output logic [7:0] rdata_o,                             // Read data, next cycle
  input wire logic init_request_i,                        // Init mode requested
  input wire logic init_acknowledge_i,                    // Init mode acknowledged
  input wire logic can_clock_select_i,                    // 0 oscillator, 1 bus clock
  input wire logic osc_clock_en_i,                        // Oscillator rate enable
  input wire logic can_rx_i,                              // Receive pin, async
  output logic quantum_tick_o,                            // One pulse per quantum
  output logic [1:0] resync_jump_width_o,                 // Jump width field
  output logic [5:0] quantum_prescaler_o,                 // Prescaler field
  output logic triple_sample_select_o,                    // Three samples per bit
  output logic [3:0] first_time_segment_o,                // First segment field
  output logic [2:0] second_time_segment_o,               // Second segment field
  output logic [4:0] bit_quanta_o,                        // Quanta per nominal bit
  output logic sample_point_o,                            // Pulse at sample point
  output logic bit_start_o,                               // Pulse at bit start
  output logic rx_bit_o,                                  // Received bit value
  output logic resync_o                                   // Pulse on resync
);
  import cbt_pkg::*;

  typedef struct packed {
    logic [7:0] prescale_jump;
    logic [7:0] segments_sampling;
    logic [7:0] rdata;
    logic rx_meta;
    logic rx_sync;
    logic [4:0] bit_quanta;
    cbt_seg_t seg;
    logic [4:0] cnt;
    logic [5:0] seg1_end;
    logic [3:0] seg2_end;
    logic prev_level;
    logic resynced;
    logic [2:0] samples;
    logic bit_value;
    logic sample_point;
    logic bit_start;
    logic resync;
  } cbt_top_state_t;

  localparam cbt_top_state_t TOP_RESET = '{
    prescale_jump: PJ_RESET,
    segments_sampling: SS_RESET,
    rdata: RDATA_RESET,
    rx_meta: 1'b1,
    rx_sync: 1'b1,
    bit_quanta: 5'h00,
    seg: CBT_SYNC,
    cnt: 5'h00,
    seg1_end: 6'h00,
    seg2_end: 4'h0,
    prev_level: 1'b1,
    resynced: 1'b0,
    samples: 3'h7,
    bit_value: 1'b1,
    sample_point: 1'b0,
    bit_start: 1'b0,
    resync: 1'b0
  };

  function automatic logic [5:0] cbt_cap(input logic [5:0] err, input logic [2:0] lim);
    cbt_cap = (err > {3'b000, lim}) ? {3'b000, lim} : err;
  endfunction

  function automatic logic cbt_majority(input logic [2:0] s);
    cbt_majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  cbt_top_state_t st;
  cbt_top_state_t next_st;
  cbt_quantum_if qif ();
  logic init_active;
  logic [4:0] seg1_len;
  logic [3:0] seg2_len;
  logic [2:0] jump_len;
  logic [7:0] status;
  logic level;
  logic edge_seen;
  logic [5:0] end1;
  logic [3:0] end2;
  logic [5:0] err2;

  assign init_active = init_request_i & init_acknowledge_i;
  assign jump_len = {1'b0, st.prescale_jump[JUMP_MSB:JUMP_LSB]} + 3'h1;
  assign seg1_len = {1'b0, st.segments_sampling[SEG1_MSB:SEG1_LSB]} + 5'h01;
  assign seg2_len = {1'b0, st.segments_sampling[SEG2_MSB:SEG2_LSB]} + 4'h1;

  assign qif.run = ~init_active;
  assign qif.clock_select = can_clock_select_i;
  assign qif.osc_clock_en = osc_clock_en_i;
  assign qif.quantum_prescaler = st.prescale_jump[PRESC_MSB:PRESC_LSB];

  cbt_quantum_gen u_quantum (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .q(qif.gen)
  );

  always_comb begin
    status = 8'h00;
    status[STAT_INIT_BIT] = init_active;
    status[STAT_RXBIT_BIT] = st.bit_value;
    status[STAT_CLKSEL_BIT] = can_clock_select_i;
    status[STAT_SEG1_BIT] = (st.seg == CBT_SEG1);
    status[STAT_SEG2_BIT] = (st.seg == CBT_SEG2);
    level = st.rx_sync;
    edge_seen = st.prev_level & ~level & ~st.resynced;
    end1 = st.seg1_end;
    end2 = st.seg2_end;
    err2 = {2'b00, st.seg2_end} - {1'b0, st.cnt};
    next_st = st;
    next_st.rdata = RDATA_RESET;
    next_st.sample_point = 1'b0;
    next_st.bit_start = 1'b0;
    next_st.resync = 1'b0;
    // Only the second flop of the pin synchroniser is read by logic
    next_st.rx_meta = can_rx_i;
    next_st.rx_sync = st.rx_meta;
    next_st.bit_quanta = 5'h01 + seg1_len + {1'b0, seg2_len};

    if (write_i && init_active) begin
      case (addr_i)
        PJ_ADDR: begin
          next_st.prescale_jump = wdata_i;
        end
        SS_ADDR: begin
          next_st.segments_sampling = wdata_i;
        end
        default: begin
        end
      endcase
    end
    if (read_i) begin
      case (addr_i)
        PJ_ADDR: next_st.rdata = st.prescale_jump;
        SS_ADDR: next_st.rdata = st.segments_sampling;
        STAT_ADDR: next_st.rdata = status;
        default: next_st.rdata = RDATA_RESET;
      endcase
    end

    // Core is parked while configuration may change under it
    if (init_active) begin
      next_st.seg = CBT_SYNC;
      next_st.cnt = 5'h00;
      next_st.prev_level = 1'b1;
      next_st.resynced = 1'b0;
      next_st.samples = 3'h7;
    end else if (qif.quantum_tick) begin
      next_st.prev_level = level;
      next_st.samples = {st.samples[1:0], level};
      case (st.seg)
        CBT_SYNC: begin
          // Edges inside the sync quantum need no correction
          next_st.seg = CBT_SEG1;
          next_st.cnt = 5'h00;
          next_st.seg1_end = {1'b0, seg1_len};
          next_st.seg2_end = seg2_len;
          next_st.resynced = 1'b0;
          next_st.bit_start = 1'b1;
        end
        CBT_SEG1: begin
          if (edge_seen) begin
            end1 = st.seg1_end + cbt_cap({1'b0, st.cnt} + 6'h01, jump_len);
            next_st.resynced = 1'b1;
            next_st.resync = 1'b1;
          end
          next_st.seg1_end = end1;
          if (({1'b0, st.cnt} + 6'h01) >= end1) begin
            next_st.sample_point = 1'b1;
            next_st.bit_value = st.segments_sampling[TRIPLE_BIT] ?
              cbt_majority({st.samples[1:0], level}) : level;
            next_st.seg = CBT_SEG2;
            next_st.cnt = 5'h00;
          end else begin
            next_st.cnt = st.cnt + 5'h01;
          end
        end
        CBT_SEG2: begin
          if (edge_seen && (err2 <= {3'b000, jump_len})) begin
            // Full correction: this quantum becomes the new sync quantum
            next_st.seg = CBT_SEG1;
            next_st.cnt = 5'h00;
            next_st.seg1_end = {1'b0, seg1_len};
            next_st.seg2_end = seg2_len;
            next_st.resynced = 1'b0;
            next_st.bit_start = 1'b1;
            next_st.resync = 1'b1;
          end else begin
            if (edge_seen) begin
              end2 = st.seg2_end - {1'b0, jump_len};
              next_st.resynced = 1'b1;
              next_st.resync = 1'b1;
            end
            next_st.seg2_end = end2;
            if (({1'b0, st.cnt[3:0]} + 5'h01) >= {1'b0, end2}) begin
              next_st.seg = CBT_SYNC;
              next_st.cnt = 5'h00;
            end else begin
              next_st.cnt = st.cnt + 5'h01;
            end
          end
        end
        default: begin
          next_st.seg = CBT_SYNC;
          next_st.cnt = 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= TOP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign quantum_tick_o = qif.quantum_tick;
  assign resync_jump_width_o = st.prescale_jump[JUMP_MSB:JUMP_LSB];
  assign quantum_prescaler_o = st.prescale_jump[PRESC_MSB:PRESC_LSB];
  assign triple_sample_select_o = st.segments_sampling[TRIPLE_BIT];
  assign first_time_segment_o = st.segments_sampling[SEG1_MSB:SEG1_LSB];
  assign second_time_segment_o = st.segments_sampling[SEG2_MSB:SEG2_LSB];
  assign bit_quanta_o = st.bit_quanta;
  assign sample_point_o = st.sample_point;
  assign bit_start_o = st.bit_start;
  assign rx_bit_o = st.bit_value;
  assign resync_o = st.resync;
endmodule
`default_nettype wire

// *** sim/cbt_top_properties.sv ***
// Purpose: Port-level checks for the CAN bit timing block
// Assumes: One clock, reset_i synchronous and high
// Notes: Bound into every cbt_top below
`timescale 1ns/1ps
`default_nettype none
module cbt_top_properties (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic [cbt_pkg::ADDR_W-1:0] addr_i, // Index
  input wire logic [7:0] wdata_i, // Write data
  input wire logic write_i, // Write
  input wire logic read_i, // Read
  input wire logic [7:0] rdata_o, // Read data
  input wire logic init_request_i, // Init request
  input wire logic init_acknowledge_i, // Init ack
  input wire logic can_clock_select_i, // Clock select
  input wire logic osc_clock_en_i, // Osc enable
  input wire logic quantum_tick_o, // Tick
  input wire logic [1:0] resync_jump_width_o, // Jump
  input wire logic [5:0] quantum_prescaler_o, // Prescale
  input wire logic triple_sample_select_o, // Triple
  input wire logic [3:0] first_time_segment_o, // Seg1
  input wire logic [2:0] second_time_segment_o, // Seg2
  input wire logic [4:0] bit_quanta_o, // Quanta
  input wire logic sample_point_o, // Sample
  input wire logic bit_start_o, // Start
  input wire logic rx_bit_o, // Bit
  input wire logic resync_o // Resync
);
  import cbt_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic init_on = init_request_i && init_acknowledge_i;
  wire logic [15:0] regs = {resync_jump_width_o, quantum_prescaler_o, triple_sample_select_o,
    second_time_segment_o, first_time_segment_o};
  property p_rd_idle; !$past(read_i) |-> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_wr_lock; write_i && !init_on |=> $stable(regs); endproperty
  a_wr_lock: assert property (p_wr_lock) else $error("write taken outside init");
  property p_wr_pj; write_i && init_on && addr_i == PJ_ADDR |=> regs[15:8] == $past(wdata_i);
  endproperty
  a_wr_pj: assert property (p_wr_pj) else $error("prescale write lost");
  property p_wr_ss; write_i && init_on && addr_i == SS_ADDR |=> regs[7:0] == $past(wdata_i);
  endproperty
  a_wr_ss: assert property (p_wr_ss) else $error("segment write lost");
  property p_quanta; !$past(reset_i) |-> bit_quanta_o == 5'($past(first_time_segment_o))
    + 5'($past(second_time_segment_o)) + 5'h03; endproperty
  a_quanta: assert property (p_quanta) else $error("bit quanta wrong");
  property p_parked; init_on [*3] |=> !quantum_tick_o && !sample_point_o && !bit_start_o;
  endproperty
  a_parked: assert property (p_parked) else $error("core runs in init");
  property p_osc; (!can_clock_select_i && !osc_clock_en_i) [*2] |=> !quantum_tick_o;
  endproperty
  a_osc: assert property (p_osc) else $error("tick without oscillator");
  property p_bus; (can_clock_select_i && quantum_prescaler_o == 6'h00 && !init_on) [*4]
    |=> quantum_tick_o; endproperty
  a_bus: assert property (p_bus) else $error("bus clock tick missing");
  property p_sp; sample_point_o |-> !bit_start_o ##1 !sample_point_o; endproperty
  a_sp: assert property (p_sp) else $error("sample point misplaced");
  property p_rx; $changed(rx_bit_o) |-> ($past(sample_point_o) or ##[0:1] sample_point_o);
  endproperty
  a_rx: assert property (p_rx) else $error("bit moved off sample point");
  property p_resync; resync_o |=> !resync_o [*2]; endproperty
  a_resync: assert property (p_resync) else $error("resync repeated");
endmodule
bind cbt_top cbt_top_properties u_props (.*);
`default_nettype wire

// *** sim/cbt_can_node.sv ***
// Purpose: Far-side CAN node driving the receive pin
// Assumes: Recessive idle level, changes just after clk_i edges
// Notes: held_o counts cycles since the level last moved
`timescale 1ns/1ps
`default_nettype none
module cbt_can_node (
  input wire logic clk_i, // Clock
  output var logic rx_o, // Bus level
  output var int held_o // Stable cycles
);
  logic level = 1'b1;
  logic prev = 1'b1;
  int held = 0;
  // One driver per port: the task moves level, never the port itself
  assign rx_o = level;
  assign held_o = held;
  always @(posedge clk_i) begin
    prev <= level;
    held <= (level != prev) ? 0 : held + 1;
  end
  task automatic send(input logic b, input int n);
    @(posedge clk_i);
    level <= b;
    repeat (n - 1) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** sim/cbt_top_tb.sv ***
// Purpose: Self-checking bench for the CAN bit timing block
// Assumes: Oscillator enable every OSC_DIV cycles
// Notes: Settings stay legal; rx checked only on settled levels
`timescale 1ns/1ps
`default_nettype none
module cbt_top_tb;
  import cbt_pkg::*;
  localparam int OSC_DIV = 3;
  logic clk_i = 1'b0, reset_i = 1'b1, write_i = 1'b0, read_i = 1'b0;
  logic init_request_i = 1'b0, init_acknowledge_i = 1'b0, can_clock_select_i = 1'b0;
  logic osc_clock_en_i = 1'b0, quantum_tick_o, triple_sample_select_o, sample_point_o;
  logic bit_start_o, rx_bit_o, resync_o, sp_d = 1'b0;
  logic [1:0] addr_i = 2'h0, resync_jump_width_o;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [5:0] quantum_prescaler_o;
  logic [3:0] first_time_segment_o;
  logic [2:0] second_time_segment_o;
  logic [4:0] bit_quanta_o;
  logic [31:0] seed = 32'hf86a;
  wire logic can_rx_i;
  int errors = 0, checks = 0, lim = 0, osc_n = 0, held, gap = 0, bc = 0, qc = 1, jw = 1;
  cbt_top DUT (.*);
  cbt_can_node node (.clk_i(clk_i), .rx_o(can_rx_i), .held_o(held));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    osc_n <= (osc_n == OSC_DIV - 1) ? 0 : osc_n + 1;
    osc_clock_en_i <= (osc_n == OSC_DIV - 1);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string w, input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", w, e, got);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input string w);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    @(negedge clk_i);
    chk(w, rdata_o, e);
  endtask
  // Period between two bit starts, bounded so a stuck core still ends
  task automatic meas(input int e);
    int n;
    n = 0;
    while (bit_start_o !== 1'b1 && n < 6000) begin
      @(negedge clk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (bit_start_o !== 1'b1 && n < 6000);
    chk("bit period", n, e);
  endtask
  // Bit length model: one correction per bit, never beyond the jump width
  always @(negedge clk_i) begin
    if (bit_start_o === 1'b1) begin
      if (lim > 0) chk("resync bound", (gap >= bc - jw * qc) && (gap <= bc + jw * qc), 1);
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
  end
  // Majority and single sampling agree once the level is settled
  always @(negedge clk_i) begin
    if (sp_d && lim > 0 && held > lim) chk("rx bit", rx_bit_o, can_rx_i);
    sp_d <= sample_point_o;
  end
  initial begin
    #2000000;
    errors++;
    end_sim;
  end
  initial begin
    int p, s1, s2, cs;
    logic [7:0] b0, b1;
    logic tr;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(PJ_ADDR, 8'h00, "reset pj");
    rd(SS_ADDR, 8'h00, "reset ss");
    rd(2'h3, 8'h00, "unmapped");
    wr(PJ_ADDR, 8'hff);
    init_request_i <= 1'b1;
    wr(SS_ADDR, 8'hff);
    rd(PJ_ADDR, 8'h00, "locked pj");
    rd(SS_ADDR, 8'h00, "half init ss");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      cs = k % 2;
      p = (k == 3) ? 63 : (k == 1) ? 0 : int'(seed[2:0]);
      s1 = 3 + int'(seed[15:12]) % 13;
      s2 = 1 + int'(seed[22:20]) % 7;
      b0 = {seed[25:24], 6'(p)};
      // Fastest setting keeps single sampling
      tr = (k == 1) ? 1'b0 : (k == 2) ? 1'b1 : seed[8];
      b1 = {tr, 3'(s2), 4'(s1)};
      @(posedge clk_i);
      init_request_i <= 1'b1;
      init_acknowledge_i <= 1'b1;
      can_clock_select_i <= cs[0];
      wr(PJ_ADDR, b0);
      wr(SS_ADDR, b1);
      rd(PJ_ADDR, b0, "pj");
      rd(SS_ADDR, b1, "ss");
      rd(STAT_ADDR, {5'h00, cs[0], 2'h3}, "status");
      chk("fields", {resync_jump_width_o, quantum_prescaler_o, triple_sample_select_o,
        second_time_segment_o, first_time_segment_o}, {b0, b1});
      chk("quanta", bit_quanta_o, 3 + s1 + s2);
      @(posedge clk_i);
      init_request_i <= 1'b0;
      init_acknowledge_i <= 1'b0;
      qc = (p + 1) * (cs ? 1 : OSC_DIV);
      bc = qc * (3 + s1 + s2);
      jw = int'(b0[7:6]) + 1;
      meas(bc);
      lim = 3 * qc + 8;
      // Odd length moves later edges off the sync quantum
      node.send(1'b0, bc + qc);
      repeat (4) begin
        seed = lfsr(seed);
        node.send(seed[3], 2 * bc);
      end
      node.send(1'b1, 2 * bc);
      lim = 0;
    end
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(PJ_ADDR, 8'h00, "rerun pj");
    rd(SS_ADDR, 8'h00, "rerun ss");
    end_sim;
  end
endmodule
`default_nettype wire
